// File: rtl/mjr_pkg.sv
package mjr_pkg;

	// Reference clock and bit time.
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_NS = 50;
	localparam int BIT_NS = 100;

	// Printed times in their own units.
	localparam int SQE_DELAY_NS = 800;
	localparam int SQE_LEN_NS   = 800;
	localparam int JAB_MS       = 50;
	localparam int UNJAB_MIN_MS = 250;
	localparam int UNJAB_MAX_MS = 750;
	localparam int RST_MIN_NS   = 2000;
	localparam int RST_EXT_NS   = 10000;

	// Cycle counts derived from the times; least times round up.
	localparam int SQE_DELAY_CYC = (SQE_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int SQE_LEN_CYC   = (SQE_LEN_NS + CLK_NS - 1) / CLK_NS;
	localparam int JAB_CYC       = JAB_MS * (CLK_HZ / 1000);
	localparam int UNJAB_CYC     = UNJAB_MIN_MS * (CLK_HZ / 1000);
	localparam int RST_EXT_CYC   = (RST_EXT_NS + CLK_NS - 1) / CLK_NS;

	// Counter widths.
	localparam int LONG_W  = 23;
	localparam int SHORT_W = 8;

	// Two-entry receive buffer.
	localparam int BUF_DEPTH = 2;
	localparam int BUF_AW    = 1;

	// Idle levels of the attachment unit pairs.
	localparam logic CI_IDLE = 1'b1;
	localparam logic DI_IDLE = 1'b1;

	// One symbol of a serial stream with its squelch flag.
	typedef struct packed {
		logic data;
		logic active;
	} mjr_sym_t;

	localparam mjr_sym_t SYM_IDLE = '{data: 1'b1, active: 1'b0};

	// Control states, one-hot.
	typedef enum logic [6:0] {
		ST_IDLE     = 7'h01,
		ST_READY    = 7'h02,
		ST_XMIT     = 7'h04,
		ST_SQE_WAIT = 7'h08,
		ST_SQE      = 7'h10,
		ST_JABBER   = 7'h20,
		ST_UNJAB    = 7'h40
	} mjr_state_t;

endpackage

// File: rtl/mjr_timer.sv
`timescale 1ns/1ps
`default_nettype none
module mjr_timer
	import mjr_pkg::*;
(
	// Clock and reset.
	input  wire logic              clock_i,
	input  wire logic              nrst_i,
	// Control.
	input  wire logic              load_i,
	input  wire logic [LONG_W-1:0] load_val_i,
	input  wire logic              en_i,
	// Status.
	output logic                   expired_o
);

	logic [LONG_W-1:0] count_ff;
	logic [LONG_W-1:0] nxt_count;

	// Load wins over counting; the count parks at zero.
	always_comb begin
		nxt_count = count_ff;
		if (load_i) begin
			nxt_count = load_val_i;
		end else if (en_i && count_ff != '0) begin
			nxt_count = count_ff - 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count_ff <= '0;
		end else begin
			count_ff <= nxt_count;
		end
	end

	assign expired_o = (count_ff == '0);

endmodule
`default_nettype wire

// File: rtl/mjr_buf2.sv
`timescale 1ns/1ps
`default_nettype none
module mjr_buf2
	import mjr_pkg::*;
(
	// Clock and reset.
	input  wire logic     clock_i,
	input  wire logic     nrst_i,
	input  wire logic     flush_i,
	// Filling side.
	input  wire logic     in_valid_i,
	output logic          in_ready_o,
	input  wire mjr_sym_t in_data_i,
	// Draining side.
	output logic          out_valid_o,
	input  wire logic     out_ready_i,
	output mjr_sym_t      out_data_o
);

	mjr_sym_t          slot_ff [BUF_DEPTH];
	logic [BUF_AW-1:0] wr_ff;
	logic [BUF_AW-1:0] rd_ff;
	logic [1:0]        cnt_ff;
	logic [BUF_AW-1:0] nxt_wr;
	logic [BUF_AW-1:0] nxt_rd;
	logic [1:0]        nxt_cnt;
	logic              push;
	logic              pop;

	// Pointer and fill bookkeeping; a full buffer refuses new words.
	always_comb begin
		in_ready_o  = (cnt_ff != 2'(BUF_DEPTH));
		out_valid_o = (cnt_ff != 2'h0);
		push        = in_valid_i && in_ready_o;
		pop         = out_valid_o && out_ready_i;
		nxt_wr      = push ? wr_ff + 1'b1 : wr_ff;
		nxt_rd      = pop ? rd_ff + 1'b1 : rd_ff;
		nxt_cnt     = 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
		if (flush_i) begin
			nxt_wr  = '0;
			nxt_rd  = '0;
			nxt_cnt = 2'h0;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= 2'h0;
		end else begin
			wr_ff  <= nxt_wr;
			rd_ff  <= nxt_rd;
			cnt_ff <= nxt_cnt;
		end
	end

	// Each entry captures the incoming word when it is the write target.
	for (genvar g = 0; g < BUF_DEPTH; g++) begin : g_slot
		mjr_sym_t nxt_slot;
		always_comb begin
			nxt_slot = slot_ff[g];
			if (push && wr_ff == BUF_AW'(g)) begin
				nxt_slot = in_data_i;
			end
		end
		always_ff @(posedge clock_i or negedge nrst_i) begin
			if (!nrst_i) begin
				slot_ff[g] <= SYM_IDLE;
			end else begin
				slot_ff[g] <= nxt_slot;
			end
		end
	end

	assign out_data_o = slot_ff[rd_ff];

endmodule
`default_nettype wire

// File: rtl/mjr_top.sv
// Contract
// - With heartbeat_select low, send an SQE burst after every transmission; the code sends none after a jabbered transmission or in test mode.
// - SQE burst is 10 MHz on CI for eight bit times.
// - SQE burst starts eight bit times after transmit activity ends.
// - With heartbeat_select high, no SQE burst is produced.
// - Transmit active beyond 50 ms stops twisted-pair transmission.
// - On jabber, disable transmitter and drive continuous 10 MHz on CI.
// - After DO goes idle, wait unjab time, then stop CI, restore transmit.
// - Transmit indicator stays inactive while jabbering.
// - Power-on reset and powerdown_reset_n both reset the block.
// - In power-down, drivers low, CI and DI high, indicators inactive.
// - Block stays idle as long as powerdown_reset_n is low.
// - After powerdown_reset_n rises, stay in reset 10 microseconds more.
// - Test pin high selects loopback; heartbeat_select picks its type.
// - Station test: DO to twisted-pair drivers, twisted-pair receive to DI.
// - Repeater test: DO looped to DI, receive retransmitted on drivers.
// - Test modes disable jabber, collision detect and collision oscillator.
// - Simultaneous DO and receive activity drives 10 MHz on CI.
`timescale 1ns/1ps
`default_nettype none
module mjr_top
	import mjr_pkg::*;
#(
	parameter logic [LONG_W-1:0] JAB_CYC_P   = LONG_W'(JAB_CYC),
	parameter logic [LONG_W-1:0] UNJAB_CYC_P = LONG_W'(UNJAB_CYC)
) (
	// Clock and power-on reset.
	input  wire logic clock_i,
	input  wire logic nrst_i,
	// Mode pins.
	input  wire logic powerdown_reset_n_i,
	input  wire logic heartbeat_select_i,
	input  wire logic test_mode_i,
	// Attachment unit side.
	input  wire logic do_data_i,
	input  wire logic do_active_i,
	output logic      di_data_o,
	output logic      di_active_o,
	input  wire logic di_ready_i,
	output logic      ci_o,
	// Twisted-pair side.
	input  wire logic tp_rx_data_i,
	input  wire logic tp_rx_active_i,
	output logic      tp_rx_ready_o,
	output logic      tp_drive_pair_o,
	output logic      tp_predistort_pair_o,
	// Status indicators.
	output logic      transmit_indicator_o,
	output logic      receive_indicator_o,
	output logic      link_ok_indicator_o,
	output logic      polarity_indicator_o
);

	mjr_state_t         st_ff;
	mjr_state_t         nxt_st;
	logic [SHORT_W-1:0] cnt_ff;
	logic [SHORT_W-1:0] nxt_cnt;
	logic [SHORT_W-1:0] rst_cnt_ff;
	logic [SHORT_W-1:0] nxt_rst_cnt;
	logic               run_w;
	logic               t_load;
	logic [LONG_W-1:0]  t_val;
	logic               t_en;
	logic               t_expired;
	logic               tx_path;
	logic               col;
	logic               osc_on;
	logic               ci_ff;
	logic               nxt_ci;
	logic               tp_ff;
	logic               nxt_tp;
	logic               pre_ff;
	logic               xmt_ff;
	logic               nxt_xmt;
	logic               rcv_ff;
	logic               nxt_rcv;
	logic               link_ff;
	mjr_sym_t           sym_in;
	mjr_sym_t           sym_out;
	logic               buf_valid;
	logic               buf_ready;

	// Reset stretch: the pin holds the counter loaded, and the block only
	// runs once the counter has drained after the pin rises.
	always_comb begin
		nxt_rst_cnt = rst_cnt_ff;
		if (!powerdown_reset_n_i) begin
			nxt_rst_cnt = SHORT_W'(RST_EXT_CYC);
		end else if (rst_cnt_ff != '0) begin
			nxt_rst_cnt = rst_cnt_ff - 1'b1;
		end
	end

	// Power-up also waits out the stretch, so both resets look alike.
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_cnt_ff <= SHORT_W'(RST_EXT_CYC);
		end else begin
			rst_cnt_ff <= nxt_rst_cnt;
		end
	end

	assign run_w = powerdown_reset_n_i && (rst_cnt_ff == '0);

	// Main control sequence: transmit, heartbeat and jabber recovery.
	always_comb begin
		nxt_st  = st_ff;
		nxt_cnt = cnt_ff;
		t_load  = 1'b0;
		t_val   = JAB_CYC_P;
		t_en    = 1'b0;
		case (st_ff)
			ST_IDLE: begin
				nxt_st = ST_READY;
			end
			ST_READY: begin
				if (do_active_i) begin
					nxt_st = ST_XMIT;
					t_load = 1'b1;
				end
			end
			ST_XMIT: begin
				t_en = 1'b1;
				if (!do_active_i) begin
					if (!heartbeat_select_i) begin
						nxt_st  = ST_SQE_WAIT;
						nxt_cnt = SHORT_W'(SQE_DELAY_CYC - 1);
					end else begin
						nxt_st = ST_READY;
					end
				end else if (t_expired) begin
					nxt_st = ST_JABBER;
				end
			end
			ST_SQE_WAIT: begin
				if (cnt_ff == '0) begin
					nxt_st  = ST_SQE;
					nxt_cnt = SHORT_W'(SQE_LEN_CYC - 1);
				end else begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
			ST_SQE: begin
				if (cnt_ff == '0) begin
					nxt_st = ST_READY;
				end else begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
			ST_JABBER: begin
				if (!do_active_i) begin
					nxt_st = ST_UNJAB;
					t_load = 1'b1;
					t_val  = UNJAB_CYC_P;
				end
			end
			ST_UNJAB: begin
				t_en = 1'b1;
				if (do_active_i) begin
					nxt_st = ST_JABBER;
				end else if (t_expired) begin
					nxt_st = ST_READY;
				end
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
		// Power-down wins over everything; test mode parks the sequence so
		// jabber and heartbeat cannot start.
		if (!run_w) begin
			nxt_st = ST_IDLE;
		end else if (test_mode_i) begin
			nxt_st = ST_READY;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_ff  <= ST_IDLE;
			cnt_ff <= '0;
		end else begin
			st_ff  <= nxt_st;
			cnt_ff <= nxt_cnt;
		end
	end

	// Long interval counter shared by jabber and unjab timing.
	mjr_timer u_timer (
		.clock_i    (clock_i),
		.nrst_i     (nrst_i),
		.load_i     (t_load),
		.load_val_i (t_val),
		.en_i       (t_en),
		.expired_o  (t_expired)
	);

	// Pin outputs. The oscillator toggles every clock, which at the 20 MHz
	// reference gives the 10 MHz CI burst without a second clock.
	always_comb begin
		tx_path = do_active_i && (st_ff == ST_READY || st_ff == ST_XMIT);
		col     = (st_ff == ST_XMIT) && do_active_i && tp_rx_active_i;
		osc_on  = run_w && !test_mode_i && (col || st_ff == ST_SQE
			|| st_ff == ST_JABBER || st_ff == ST_UNJAB);
		nxt_ci  = osc_on ? ~ci_ff : CI_IDLE;
		nxt_tp  = 1'b0;
		if (!run_w) begin
			nxt_tp = 1'b0;
		end else if (test_mode_i) begin
			nxt_tp = heartbeat_select_i ? tp_rx_data_i
				: do_data_i;
		end else if (tx_path) begin
			nxt_tp = do_data_i;
		end
		nxt_xmt = run_w && !test_mode_i && tx_path;
		nxt_rcv = run_w && tp_rx_active_i;
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ci_ff   <= CI_IDLE;
			tp_ff   <= 1'b0;
			pre_ff  <= 1'b0;
			xmt_ff  <= 1'b0;
			rcv_ff  <= 1'b0;
			link_ff <= 1'b0;
		end else begin
			ci_ff   <= nxt_ci;
			tp_ff   <= nxt_tp;
			pre_ff  <= run_w ? tp_ff : 1'b0;
			xmt_ff  <= nxt_xmt;
			rcv_ff  <= nxt_rcv;
			link_ff <= run_w;
		end
	end

	// Receive path toward DI goes through the buffer so a stalled
	// receiver does not drop symbols; repeater test feeds DO in instead.
	always_comb begin
		if (test_mode_i && heartbeat_select_i) begin
			sym_in = '{data: do_data_i, active: do_active_i};
		end else begin
			sym_in = '{data: tp_rx_data_i, active: tp_rx_active_i};
		end
	end

	mjr_buf2 u_buf (
		.clock_i     (clock_i),
		.nrst_i      (nrst_i),
		.flush_i     (!run_w),
		.in_valid_i  (run_w && sym_in.active),
		.in_ready_o  (buf_ready),
		.in_data_i   (sym_in),
		.out_valid_o (buf_valid),
		.out_ready_i (di_ready_i),
		.out_data_o  (sym_out)
	);

	assign tp_rx_ready_o        = buf_ready;
	assign di_data_o            = buf_valid ? sym_out.data : DI_IDLE;
	assign di_active_o          = buf_valid;
	assign ci_o                 = ci_ff;
	assign tp_drive_pair_o      = tp_ff;
	assign tp_predistort_pair_o = pre_ff;
	assign transmit_indicator_o = xmt_ff;
	assign receive_indicator_o  = rcv_ff;
	assign link_ok_indicator_o  = link_ff;
	assign polarity_indicator_o = 1'b0;

	// Checks.
	// Eight quiet cycles; two in a row span the sixteen-clock heartbeat gap
	// without asking the tools to unroll a long repetition.
	sequence s_quiet8;
		(run_w && !test_mode_i)[*8];
	endsequence

	sequence s_sqe_trig;
		st_ff == ST_XMIT && !do_active_i && !heartbeat_select_i
			&& run_w && !test_mode_i;
	endsequence

	a_sqe_start_gap: assert property (@(posedge clock_i) disable iff (!nrst_i)
		s_sqe_trig ##1 s_quiet8 ##1 s_quiet8 |=> st_ff == ST_SQE)
		else $error("SQE burst did not start after the gap");

	a_sqe_burst_osc: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(st_ff == ST_SQE && run_w && !test_mode_i) |=> ci_ff != $past(ci_ff))
		else $error("CI not toggling during SQE burst");

	a_hb_off_quiet: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(st_ff == ST_XMIT && !do_active_i && heartbeat_select_i)
			|=> st_ff != ST_SQE_WAIT)
		else $error("SQE started with heartbeat disabled");

	a_jab_ci_tx: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(st_ff == ST_JABBER && run_w && !test_mode_i)
			|=> ci_ff != $past(ci_ff) && !tp_ff && !xmt_ff)
		else $error("Jabber did not silence transmit or drive CI");

	a_idle_pins: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!powerdown_reset_n_i |=> !tp_ff && ci_ff && !xmt_ff && !rcv_ff
			&& !link_ff && di_data_o)
		else $error("Idle pin levels wrong in power-down");

	a_rst_stretch: assert property (@(posedge clock_i) disable iff (!nrst_i)
		$rose(powerdown_reset_n_i) |-> rst_cnt_ff == SHORT_W'(RST_EXT_CYC)
			##1 (rst_cnt_ff != '0 && st_ff == ST_IDLE))
		else $error("Reset stretch not held after pin release");

	a_test_no_jab: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(test_mode_i && run_w) |=> st_ff == ST_READY && !xmt_ff)
		else $error("Test mode left jabber or collision logic active");

	a_station_loop: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(test_mode_i && !heartbeat_select_i && run_w)
			|=> tp_ff == $past(do_data_i))
		else $error("Station test did not send DO to the drivers");

	a_col_osc: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(col && run_w && !test_mode_i) |=> ci_ff != $past(ci_ff))
		else $error("Collision did not toggle CI");

endmodule
`default_nettype wire

// File: testbench/mjr_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Station on the attachment unit side: sends DO frames and sinks DI symbols.
module mjr_partner (
	// Clock and stall request.
	input  wire logic clock_i,
	input  wire logic stall_i,
	// Attachment unit pairs.
	output logic      do_data_o,
	output logic      do_active_o,
	input  wire logic di_data_i,
	input  wire logic di_active_i,
	output logic      di_ready_o
);
	logic got[$];
	logic sent[$];
	logic sending;

	initial begin
		do_data_o = 1'b1;
		do_active_o = 1'b0;
		di_ready_o = 1'b1;
		sending = 1'b0;
	end

	// Random stalls; the idle DO line toggles so no stale bit looks valid.
	always @(negedge clock_i) begin
		di_ready_o <= !stall_i || ($urandom % 3 != 0);
		if (!sending)
			do_data_o <= ~do_data_o;
		#5;
		if (di_active_i === 1'b1 && di_ready_o === 1'b1)
			got.push_back(di_data_i);
	end

	// One frame of random bits, one bit per clock.
	task automatic send(input int n);
		logic b;
		sending = 1'b1;
		for (int i = 0; i < n; i++) begin
			@(negedge clock_i);
			b = 1'($urandom);
			do_data_o = b;
			do_active_o = 1'b1;
			sent.push_back(b);
		end
		@(negedge clock_i);
		do_active_o = 1'b0;
		sending = 1'b0;
	endtask
endmodule
`default_nettype wire

// File: testbench/test_mjr_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_mjr_top;
	import mjr_pkg::*;
	// Short jabber and unjab counts keep the run brief.
	localparam int JAB = 40;
	localparam int UNJ = 60;
	logic clock_i, nrst_i, pd_n, hb, tm, rx_d, rx_a, stall, chk, e_v, e_d;
	logic do_d, do_a, di_d, di_a, di_rdy, ci, rx_rdy, tp, tpp;
	logic transmit_indicator, receive_indicator, lnk, pol;
	logic rxq[$];
	int   bad_count, cmp_count, n;

	mjr_top #(.JAB_CYC_P(LONG_W'(JAB)), .UNJAB_CYC_P(LONG_W'(UNJ))) dut (
		.clock_i(clock_i), .nrst_i(nrst_i),
		.powerdown_reset_n_i(pd_n), .heartbeat_select_i(hb),
		.test_mode_i(tm), .do_data_i(do_d), .do_active_i(do_a),
		.di_data_o(di_d), .di_active_o(di_a), .di_ready_i(di_rdy),
		.ci_o(ci), .tp_rx_data_i(rx_d), .tp_rx_active_i(rx_a),
		.tp_rx_ready_o(rx_rdy), .tp_drive_pair_o(tp),
		.tp_predistort_pair_o(tpp), .transmit_indicator_o(transmit_indicator),
		.receive_indicator_o(receive_indicator), .link_ok_indicator_o(lnk),
		.polarity_indicator_o(pol));

	mjr_partner part (
		.clock_i(clock_i), .stall_i(stall), .do_data_o(do_d),
		.do_active_o(do_a), .di_data_i(di_d), .di_active_i(di_a),
		.di_ready_o(di_rdy));

	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end

	task automatic cmp_bit(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic cmp_cnt(input string nm, input int e, input int g);
		cmp_count++;
		if (g != e) begin
			bad_count++;
			$display("[FAIL] %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Counts CI changes over k clocks; a 10 MHz burst changes every clock.
	task automatic ci_edges(input int k, output int c);
		logic p;
		c = 0;
		p = ci;
		repeat (k) begin
			@(negedge clock_i);
			if (ci !== p)
				c++;
			p = ci;
		end
	endtask

	// Receive pair source; a refused symbol is held until it is taken.
	task automatic recv(input int k);
		int   i;
		logic r;
		i = 0;
		r = 1'b1;
		while (i < k) begin
			@(negedge clock_i);
			if (r === 1'b1)
				rx_d = 1'($urandom);
			rx_a = 1'b1;
			#5 r = rx_rdy;
			if (r === 1'b1) begin
				rxq.push_back(rx_d);
				i++;
			end
		end
		@(negedge clock_i);
		rx_a = 1'b0;
		rx_d = ~rx_d;
	endtask

	// Drains the receiver and compares DI with the queued model.
	task automatic chk_di();
		repeat (40) @(negedge clock_i);
		cmp_cnt("di_count", rxq.size(), part.got.size());
		while (rxq.size() > 0 && part.got.size() > 0)
			cmp_bit("di_data", rxq.pop_front(), part.got.pop_front());
		rxq.delete();
		part.got.delete();
	endtask

	// Expected driver bit is the selected source one edge earlier.
	always @(posedge clock_i) begin
		e_v <= (tm && hb) ? rx_a : do_a;
		e_d <= (tm && hb) ? rx_d : do_d;
	end
	always @(negedge clock_i)
		if (chk && e_v)
			cmp_bit("tp_drive", e_d, tp);

	// Watchdog sized well above the expected run of about a thousand clocks.
	initial begin
		#(CLK_NS * 20000);
		bad_count++;
		conclude();
	end

	initial begin
		nrst_i = 1'b0;
		pd_n = 1'b1;
		hb = 1'b0;
		tm = 1'b0;
		rx_d = 1'b0;
		rx_a = 1'b0;
		stall = 1'b0;
		chk = 1'b0;
		bad_count = 0;
		cmp_count = 0;
		void'($urandom(32'h0fc1));
		repeat (16) @(negedge clock_i);
		cmp_bit("ci_por", 1'b1, ci);
		nrst_i = 1'b1;
		repeat (205) @(negedge clock_i);
		cmp_bit("link_por", 1'b1, lnk);
		pd_n = 1'b0;
		repeat (40) @(negedge clock_i);
		cmp_bit("tp_idle", 1'b0, tp);
		cmp_bit("tpp_idle", 1'b0, tpp);
		cmp_bit("ci_idle", 1'b1, ci);
		cmp_bit("di_idle", 1'b1, di_d);
		cmp_bit("ind_idle", 1'b0, transmit_indicator | receive_indicator | lnk | pol);
		pd_n = 1'b1;
		repeat (190) @(negedge clock_i);
		cmp_bit("link_stretch", 1'b0, lnk);
		repeat (15) @(negedge clock_i);
		cmp_bit("link_run", 1'b1, lnk);
		chk = 1'b1;
		for (int h = 0; h < 2; h++) begin
			hb = 1'(h);
			fork
				part.send(30);
				begin
					repeat (5) @(negedge clock_i);
					cmp_bit("xmt", 1'b1, transmit_indicator);
				end
			join
			ci_edges(16, n);
			cmp_cnt("sqe_gap", 0, n);
			ci_edges(25, n);
			cmp_cnt("sqe_len", h ? 0 : 16, n);
		end
		hb = 1'b0;
		chk = 1'b0;
		fork
			part.send(JAB + 30);
			begin
				repeat (JAB + 10) @(negedge clock_i);
				cmp_bit("tp_jab", 1'b0, tp);
				cmp_bit("xmt_jab", 1'b0, transmit_indicator);
				ci_edges(10, n);
				cmp_cnt("ci_jab", 10, n);
			end
		join
		ci_edges(UNJ - 10, n);
		cmp_cnt("ci_unjab", UNJ - 10, n);
		ci_edges(30, n);
		ci_edges(10, n);
		cmp_cnt("ci_unjab_end", 0, n);
		// Collision with a stalling receiver also restores the transmit path.
		chk = 1'b1;
		stall = 1'b1;
		fork
			part.send(40);
			begin
				repeat (3) @(negedge clock_i);
				recv(20);
			end
			begin
				repeat (8) @(negedge clock_i);
				ci_edges(10, n);
				cmp_cnt("ci_coll", 10, n);
			end
		join
		chk_di();
		stall = 1'b0;
		tm = 1'b1;
		for (int h = 0; h < 2; h++) begin
			hb = 1'(h);
			part.sent.delete();
			repeat (4) @(negedge clock_i);
			fork
				part.send(24);
				recv(12);
				begin
					repeat (6) @(negedge clock_i);
					ci_edges(10, n);
					cmp_cnt("ci_test", 0, n);
				end
			join
			ci_edges(30, n);
			cmp_cnt("heartbeat_select", 0, n);
			if (h)
				rxq = part.sent;
			chk_di();
		end
		conclude();
	end
endmodule
`default_nettype wire
